// [bench/rpg_record_path_assertions.sv]
// Port checker for the record path gain, mute and filter block
`timescale 1ns/1ps
`default_nettype none

module rpg_record_path_assertions (
    // Clock and reset
    input wire logic                 ref_clk_i,
    input wire logic                 reset_i,
    // Register port
    input wire logic [7:0]           reg_addr_i,
    input wire logic                 reg_wr_i,
    input wire logic [15:0]          reg_wdata_i,
    input wire logic                 reg_rd_i,
    input wire logic [15:0]          reg_rdata_o,
    // Sample stream
    input wire logic                 in_valid_i,
    input wire rpg_pkg::rpg_sample_t in_left_i,
    input wire rpg_pkg::rpg_sample_t in_right_i,
    input wire logic                 in_ready_o,
    input wire logic                 out_valid_o,
    input wire rpg_pkg::rpg_sample_t out_left_o,
    input wire rpg_pkg::rpg_sample_t out_right_o,
    input wire logic                 out_ready_i
);
    // ----------------------------------------
    // Shadow of the control state
    // ----------------------------------------
    logic [15:0] pw_r, pw_nxt, mu_r, mu_nxt, fc_r, fc_nxt;
    logic [15:0] lg_r, lg_nxt, rg_r, rg_nxt;
    logic [7:0]  la_r, la_nxt, ra_r, ra_nxt;
    logic        l_off, r_off, l_one, r_one;

    always_comb begin
        pw_nxt = pw_r;
        mu_nxt = mu_r;
        fc_nxt = fc_r;
        lg_nxt = lg_r;
        rg_nxt = rg_r;
        la_nxt = la_r;
        ra_nxt = ra_r;
        if (reg_wr_i) begin
            case (reg_addr_i)
                8'h02: pw_nxt = reg_wdata_i & 16'h0C00;
                8'h19: mu_nxt = reg_wdata_i & 16'h0100;
                8'h1A: fc_nxt = reg_wdata_i & 16'h0007;
                8'h1B: lg_nxt = reg_wdata_i & 16'h01FF;
                8'h1C: rg_nxt = reg_wdata_i & 16'h01FF;
                default: ;
            endcase
            // Either gain register carries the shared strobe
            if (reg_wdata_i[12] && (reg_addr_i == 8'h1B || reg_addr_i == 8'h1C)) begin
                la_nxt = lg_nxt[7:0];
                ra_nxt = rg_nxt[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pw_r <= 16'h0000;
            mu_r <= 16'h0000;
            fc_r <= 16'h0000;
            lg_r <= 16'h00C0;
            rg_r <= 16'h00C0;
            la_r <= 8'hC0;
            ra_r <= 8'hC0;
        end else begin
            pw_r <= pw_nxt;
            mu_r <= mu_nxt;
            fc_r <= fc_nxt;
            lg_r <= lg_nxt;
            rg_r <= rg_nxt;
            la_r <= la_nxt;
            ra_r <= ra_nxt;
        end
    end

    assign l_off = !pw_r[10] || lg_r[8] || mu_r[8] || la_r == 8'h00;
    assign r_off = !pw_r[11] || rg_r[8] || mu_r[8] || ra_r == 8'h00;
    assign l_one = !l_off && !fc_r[0] && la_r == 8'hC0;
    assign r_one = !r_off && !fc_r[0] && ra_r == 8'hC0;

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    // Empty buffer: the taken pair is the next one shown
    sequence s_take;
        in_valid_i && in_ready_o && !out_valid_o;
    endsequence
    sequence s_read(logic [7:0] a);
        reg_rd_i && reg_addr_i == a;
    endsequence

    property p_answer;
        s_take |=> out_valid_o;
    endproperty
    property p_left_off;
        s_take ##0 l_off |=> out_left_o == 24'h000000;
    endproperty
    property p_right_off;
        s_take ##0 r_off |=> out_right_o == 24'h000000;
    endproperty
    property p_global_mute;
        s_take ##0 mu_r[8] |=> out_left_o == 24'h000000 && out_right_o == 24'h000000;
    endproperty
    property p_left_unity;
        s_take ##0 l_one |=> out_left_o == $past(in_left_i);
    endproperty
    property p_right_unity;
        s_take ##0 r_one |=> out_right_o == $past(in_right_i);
    endproperty
    property p_read_gain;
        s_read(8'h1B) |=> reg_rdata_o == $past(lg_r);
    endproperty
    property p_read_filter;
        s_read(8'h1A) |=> reg_rdata_o == $past(fc_r);
    endproperty
    property p_stall_holds;
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_left_o)
            && $stable(out_right_o);
    endproperty

    a_answer: assert property (p_answer) else $error("No pair after take");
    a_left_off: assert property (p_left_off) else $error("Left not silent");
    a_right_off: assert property (p_right_off) else $error("Right not silent");
    a_global_mute: assert property (p_global_mute) else $error("Global mute leak");
    a_left_unity: assert property (p_left_unity) else $error("Left unity wrong");
    a_right_unity: assert property (p_right_unity) else $error("Right unity wrong");
    a_read_gain: assert property (p_read_gain) else $error("Gain readback wrong");
    a_read_filter: assert property (p_read_filter) else $error("Filter readback");
    a_stall_holds: assert property (p_stall_holds) else $error("Output moved in stall");
endmodule

`default_nettype wire

// [bench/rpg_record_path_test.sv]
// Self-checking bench for the record path gain, mute and filter block
`timescale 1ns/1ps
`default_nettype none

module rpg_record_path_test;
    logic                 ref_clk_i = 1'b0;
    logic                 reset_i = 1'b1;
    logic [7:0]           reg_addr_i = 8'h00;
    logic                 reg_wr_i = 1'b0;
    logic [15:0]          reg_wdata_i = 16'h0000;
    logic                 reg_rd_i = 1'b0;
    logic [15:0]          reg_rdata_o;
    logic                 in_valid_i = 1'b0;
    rpg_pkg::rpg_sample_t in_left_i = 24'h000000;
    rpg_pkg::rpg_sample_t in_right_i = 24'h000000;
    logic                 in_ready_o, out_valid_o, out_ready_i;
    rpg_pkg::rpg_sample_t out_left_o, out_right_o;
    logic                 stall = 1'b0;
    int                   mismatches = 0;
    int                   checks = 0;

    always #5 ref_clk_i = !ref_clk_i;

    rpg_record_path rpg_record_path_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .in_valid_i(in_valid_i),
        .in_left_i(in_left_i), .in_right_i(in_right_i), .in_ready_o(in_ready_o),
        .out_valid_o(out_valid_o), .out_left_o(out_left_o), .out_right_o(out_right_o),
        .out_ready_i(out_ready_i));
    rpg_sink_model rpg_sink_model_i (.ref_clk_i(ref_clk_i), .stall_i(stall),
        .out_valid_i(out_valid_o), .left_i(out_left_o), .right_i(out_right_o),
        .ready_o(out_ready_i));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge ref_clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge ref_clk_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(negedge ref_clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge ref_clk_i);
        reg_rd_i = 1'b0;
        d = reg_rdata_o;
    endtask

    task automatic send(input logic [23:0] l, input logic [23:0] r);
        int n = 0;
        @(negedge ref_clk_i);
        in_valid_i = 1'b1;
        in_left_i = l;
        in_right_i = r;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (!in_ready_o && n < 50);
        if (!in_ready_o) mismatches++;
        @(negedge ref_clk_i);
        in_valid_i = 1'b0;
        // Released lines must not keep looking valid
        in_left_i = ~l;
        in_right_i = ~r;
    endtask

    task automatic take(output logic [23:0] l, output logic [23:0] r);
        logic [47:0] w = 48'hX;
        int n = 0;
        while (rpg_sink_model_i.got_q.size() == 0 && n < 50) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (rpg_sink_model_i.got_q.size() > 0) w = rpg_sink_model_i.got_q.pop_front();
        l = w[47:24];
        r = w[23:0];
    endtask

    task automatic pair(input logic [23:0] xl, input logic [23:0] xr,
                        output logic [23:0] l, output logic [23:0] r);
        send(xl, xr);
        take(l, r);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        logic [7:0]  a[6] = '{8'h02, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h33};
        logic [15:0] e[6] = '{16'h0000, 16'h0000, 16'h0000, 16'h00C0, 16'h00C0, 16'h0000};
        logic [15:0] d;
        wr(8'h33, 16'hFFFF);
        for (int i = 0; i < 6; i++) begin
            rd(a[i], d);
            check(d, e[i]);
        end
        wr(8'h1A, 16'hFFFF);
        rd(8'h1A, d);
        check(d, 16'h0007);
        wr(8'h1A, 16'h0000);
        wr(8'h1B, 16'hEFFF);
        rd(8'h1B, d);
        check(d, 16'h01FF);
        wr(8'h1B, 16'h10C0);
        rd(8'h1B, d);
        check(d, 16'h00C0);
    endtask

    task automatic t_enable;
        logic [23:0] l, r;
        pair(24'h123456, 24'h654321, l, r);
        check(l, 24'h000000);
        check(r, 24'h000000);
        wr(8'h02, 16'h0400);
        pair(24'h123456, 24'h654321, l, r);
        check(l, 24'h123456);
        check(r, 24'h000000);
        wr(8'h02, 16'h0C00);
        pair(24'h123456, 24'h654321, l, r);
        check(r, 24'h654321);
    endtask

    task automatic t_gain;
        logic [7:0]  g[7] = '{8'hC0, 8'hD0, 8'hD0, 8'hB0, 8'h80, 8'h00, 8'hE0};
        logic [23:0] x[7] = '{24'hFFFFFD, 24'h500000, 24'hA00000, 24'hFFFFFD,
                              24'h000100, 24'h7FFFFF, 24'h000010};
        logic [23:0] y[7] = '{24'hFFFFFD, 24'h7FFFFF, 24'h800000, 24'hFFFFFE,
                              24'h000010, 24'h000000, 24'h000040};
        logic [23:0] l, r;
        wr(8'h1B, 16'h00D0);
        pair(24'h001000, 24'h001000, l, r);
        check(l, 24'h001000);
        wr(8'h1C, 16'h10B0);
        pair(24'h001000, 24'h001000, l, r);
        check(l, 24'h002000);
        check(r, 24'h000800);
        wr(8'h1C, 16'h00C0);
        for (int i = 0; i < 7; i++) begin
            wr(8'h1B, {8'h10, g[i]});
            pair(x[i], x[i], l, r);
            check(l, y[i]);
            check(r, x[i]);
        end
        wr(8'h1B, 16'h10C0);
    endtask

    task automatic t_mute;
        logic [23:0] l, r;
        wr(8'h1B, 16'h01C0);
        pair(24'h000100, 24'h000200, l, r);
        check(l, 24'h000000);
        check(r, 24'h000200);
        wr(8'h1B, 16'h00C0);
        wr(8'h19, 16'h0100);
        pair(24'h000100, 24'h000200, l, r);
        check(l, 24'h000000);
        check(r, 24'h000000);
        wr(8'h19, 16'h0000);
        wr(8'h1C, 16'h01C0);
        pair(24'h000100, 24'h000200, l, r);
        check(l, 24'h000100);
        check(r, 24'h000000);
        wr(8'h1C, 16'h00C0);
    endtask

    task automatic t_hpf;
        logic [23:0] l, r, prev;
        prev = 24'h100000;
        for (int c = 0; c < 4; c++) begin
            wr(8'h1A, 16'(2 * c + 1));
            for (int k = 0; k < 6; k++) pair(24'h100000, 24'h100000, l, r);
            // Higher cut-off drains a DC step faster
            check({23'h0, $signed(l) < $signed(prev)}, 24'h000001);
            prev = l;
            wr(8'h1A, 16'h0000);
        end
        pair(24'h100000, 24'h100000, l, r);
        check(l, 24'h100000);
    endtask

    task automatic t_buffer;
        logic [23:0] l, r;
        @(negedge ref_clk_i);
        stall = 1'b1;
        send(24'h000011, 24'h000012);
        send(24'h000021, 24'h000022);
        repeat (3) @(negedge ref_clk_i);
        check({23'h0, in_ready_o}, 24'h000000);
        check(out_left_o, 24'h000011);
        stall = 1'b0;
        take(l, r);
        check(r, 24'h000012);
        take(l, r);
        check(l, 24'h000021);
        @(negedge ref_clk_i);
        check({23'h0, out_valid_o}, 24'h000000);
    endtask

    // ----------------------------------------
    // Sequence and verdict
    // ----------------------------------------
    task automatic give_verdict;
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(negedge ref_clk_i);
        reset_i = 1'b0;
        t_regs;
        t_enable;
        t_gain;
        t_mute;
        t_hpf;
        t_buffer;
        give_verdict;
    end

    // Whole run needs a few hundred cycles
    initial begin
        #200000;
        mismatches++;
        give_verdict;
    end
endmodule

bind rpg_record_path rpg_record_path_assertions rpg_record_path_assertions_i (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .in_valid_i(in_valid_i), .in_left_i(in_left_i),
    .in_right_i(in_right_i), .in_ready_o(in_ready_o), .out_valid_o(out_valid_o),
    .out_left_o(out_left_o), .out_right_o(out_right_o), .out_ready_i(out_ready_i));

`default_nettype wire

// [bench/rpg_sink_model.sv]
// Receiver model that collects processed pairs and can stall
`timescale 1ns/1ps
`default_nettype none

module rpg_sink_model (
    // Clock and stall control
    input  wire logic                 ref_clk_i,
    input  wire logic                 stall_i,
    // Pair stream
    input  wire logic                 out_valid_i,
    input  wire rpg_pkg::rpg_sample_t left_i,
    input  wire rpg_pkg::rpg_sample_t right_i,
    output var  logic                 ready_o
);
    logic [47:0] got_q[$];

    initial ready_o = 1'b1;

    // Ready moves only off the sampling edge
    always @(negedge ref_clk_i) ready_o <= !stall_i;

    always @(posedge ref_clk_i) begin
        if (out_valid_i && ready_o) got_q.push_back({left_i, right_i});
    end
endmodule

`default_nettype wire

// [design/rpg_defs.svh]
// Register offsets, field positions, reset values and filter constants
`ifndef RPG_DEFS_SVH
`define RPG_DEFS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define RPG_ADDR_POWER   8'h02
`define RPG_ADDR_MUTE    8'h19
`define RPG_ADDR_FILT    8'h1A
`define RPG_ADDR_LGAIN   8'h1B
`define RPG_ADDR_RGAIN   8'h1C

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RPG_BIT_LEFT_EN  10
`define RPG_BIT_RIGHT_EN 11
`define RPG_BIT_GMUTE    8
`define RPG_BIT_HPF_EN   0
`define RPG_CUT_LSB      1
`define RPG_CUT_MSB      2
`define RPG_BIT_UPDATE   12
`define RPG_BIT_CHMUTE   8
`define RPG_GAIN_MSB     7

// ------------------------------------------------------------
// Reset values and arithmetic constants
// ------------------------------------------------------------
`define RPG_GAIN_RST     8'hC0
`define RPG_GAIN_UNITY   9'h0C0
`define RPG_GAIN_SHIFT0  6'h11
`define RPG_FRAC         8
// Pole coefficients, Q16, as 2*pi*fc/fs at the 48 kHz reference
`define RPG_K_CUT0       17'h00022
`define RPG_K_CUT1       17'h00417
`define RPG_K_CUT2       17'h00521
`define RPG_K_CUT3       17'h00692

`endif

// [design/rpg_pair_buffer.sv]
// Small FIFO holding processed stereo words ahead of the receiver
`timescale 1ns/1ps
`default_nettype none

module rpg_pair_buffer #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             reset_i,
    // Filling side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // Draining side
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wr_r;
    logic [PW-1:0]    wr_nxt;
    logic [PW-1:0]    rd_r;
    logic [PW-1:0]    rd_nxt;
    logic [CW-1:0]    cnt_r;
    logic [CW-1:0]    cnt_nxt;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_r != CW'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rd_r];

    always_comb begin
        push    = in_valid_i && in_ready_o;
        pop     = out_valid_o && out_ready_i;
        wr_nxt  = wr_r;
        rd_nxt  = rd_r;
        cnt_nxt = cnt_r;
        if (push) begin
            wr_nxt = (wr_r == PW'(DEPTH - 1)) ? '0 : PW'(wr_r + 1'b1);
        end
        if (pop) begin
            rd_nxt = (rd_r == PW'(DEPTH - 1)) ? '0 : PW'(rd_r + 1'b1);
        end
        if (push && !pop) begin
            cnt_nxt = CW'(cnt_r + 1'b1);
        end else if (pop && !push) begin
            cnt_nxt = CW'(cnt_r - 1'b1);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage needs no reset; empty flag guards it
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_r[wr_r] <= in_data_i;
        end
    end

endmodule

`default_nettype wire

// [design/rpg_pkg.sv]
// Types shared by the record path gain and high-pass design
package rpg_pkg;

    typedef logic signed [23:0] rpg_sample_t;
    typedef logic [7:0]         rpg_gain_t;
    typedef logic signed [39:0] rpg_acc_t;

    typedef enum logic [1:0] {
        cut_dc   = 2'b00,
        cut_low  = 2'b01,
        cut_mid  = 2'b10,
        cut_high = 2'b11
    } rpg_cut_e;

endpackage

// [design/rpg_record_path.sv]
// Record path: per-channel enable, high-pass filter, digital gain and mute
`timescale 1ns/1ps
`default_nettype none
`include "rpg_defs.svh"

module rpg_record_path (
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 reset_i,
    // Register port
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic                 reg_wr_i,
    input  wire logic [15:0]          reg_wdata_i,
    input  wire logic                 reg_rd_i,
    output logic [15:0]               reg_rdata_o,
    // Sample input
    input  wire logic                 in_valid_i,
    input  wire rpg_pkg::rpg_sample_t in_left_i,
    input  wire rpg_pkg::rpg_sample_t in_right_i,
    output logic                      in_ready_o,
    // Sample output
    output logic                      out_valid_o,
    output rpg_pkg::rpg_sample_t      out_left_o,
    output rpg_pkg::rpg_sample_t      out_right_o,
    input  wire logic                 out_ready_i
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // 2^(m/16) in Q14; sixteen steps of about 0.376 dB make exactly one octave (6.02 dB)
    function automatic logic [14:0] gain_mant(input logic [3:0] m);
        case (m)
            4'h0:    gain_mant = 15'h4000;
            4'h1:    gain_mant = 15'h42D5;
            4'h2:    gain_mant = 15'h45CB;
            4'h3:    gain_mant = 15'h48E2;
            4'h4:    gain_mant = 15'h4C1C;
            4'h5:    gain_mant = 15'h4F7B;
            4'h6:    gain_mant = 15'h52FF;
            4'h7:    gain_mant = 15'h56AC;
            4'h8:    gain_mant = 15'h5A82;
            4'h9:    gain_mant = 15'h5E84;
            4'hA:    gain_mant = 15'h62B4;
            4'hB:    gain_mant = 15'h6712;
            4'hC:    gain_mant = 15'h6BA2;
            4'hD:    gain_mant = 15'h7066;
            4'hE:    gain_mant = 15'h7560;
            default: gain_mant = 15'h7A93;
        endcase
    endfunction

    function automatic rpg_pkg::rpg_sample_t sat24(input logic signed [47:0] v);
        if (v > 48'sh0000_007F_FFFF) begin
            sat24 = 24'sh7F_FFFF;
        end else if (v < -48'sh0000_0080_0000) begin
            sat24 = -24'sh80_0000;
        end else begin
            sat24 = v[23:0];
        end
    endfunction

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [1:0]                conv_en_r;
    logic [1:0]                conv_en_nxt;
    logic                      gmute_r;
    logic                      gmute_nxt;
    logic                      hpf_en_r;
    logic                      hpf_en_nxt;
    rpg_pkg::rpg_cut_e         cut_r;
    rpg_pkg::rpg_cut_e         cut_nxt;
    rpg_pkg::rpg_gain_t [1:0]  pend_r;
    rpg_pkg::rpg_gain_t [1:0]  pend_nxt;
    rpg_pkg::rpg_gain_t [1:0]  appl_r;
    rpg_pkg::rpg_gain_t [1:0]  appl_nxt;
    logic [1:0]                mute_r;
    logic [1:0]                mute_nxt;
    logic [15:0]               rdata_r;
    logic [15:0]               rdata_nxt;
    logic                      update;

    always_comb begin
        conv_en_nxt = conv_en_r;
        gmute_nxt   = gmute_r;
        hpf_en_nxt  = hpf_en_r;
        cut_nxt     = cut_r;
        pend_nxt    = pend_r;
        mute_nxt    = mute_r;
        appl_nxt    = appl_r;
        rdata_nxt   = rdata_r;
        update      = 1'b0;
        if (reg_wr_i) begin
            case (reg_addr_i)
                `RPG_ADDR_POWER: begin
                    conv_en_nxt[0] = reg_wdata_i[`RPG_BIT_LEFT_EN];
                    conv_en_nxt[1] = reg_wdata_i[`RPG_BIT_RIGHT_EN];
                end
                `RPG_ADDR_MUTE: gmute_nxt = reg_wdata_i[`RPG_BIT_GMUTE];
                `RPG_ADDR_FILT: begin
                    hpf_en_nxt = reg_wdata_i[`RPG_BIT_HPF_EN];
                    cut_nxt    = rpg_pkg::rpg_cut_e'(reg_wdata_i[`RPG_CUT_MSB:`RPG_CUT_LSB]);
                end
                `RPG_ADDR_LGAIN: begin
                    pend_nxt[0] = reg_wdata_i[`RPG_GAIN_MSB:0];
                    mute_nxt[0] = reg_wdata_i[`RPG_BIT_CHMUTE];
                    update      = reg_wdata_i[`RPG_BIT_UPDATE];
                end
                `RPG_ADDR_RGAIN: begin
                    pend_nxt[1] = reg_wdata_i[`RPG_GAIN_MSB:0];
                    mute_nxt[1] = reg_wdata_i[`RPG_BIT_CHMUTE];
                    update      = reg_wdata_i[`RPG_BIT_UPDATE];
                end
                default: ;
            endcase
        end
        // Whole samples are computed in one cycle, so a register swap never splits one
        if (update) begin
            appl_nxt = pend_nxt;
        end
        if (reg_rd_i) begin
            rdata_nxt = 16'h0000;
            case (reg_addr_i)
                `RPG_ADDR_POWER: begin
                    rdata_nxt[`RPG_BIT_LEFT_EN]  = conv_en_r[0];
                    rdata_nxt[`RPG_BIT_RIGHT_EN] = conv_en_r[1];
                end
                `RPG_ADDR_MUTE: rdata_nxt[`RPG_BIT_GMUTE] = gmute_r;
                `RPG_ADDR_FILT: begin
                    rdata_nxt[`RPG_BIT_HPF_EN]             = hpf_en_r;
                    rdata_nxt[`RPG_CUT_MSB:`RPG_CUT_LSB] = cut_r;
                end
                // Update bit is a strobe and always reads zero
                `RPG_ADDR_LGAIN: begin
                    rdata_nxt[`RPG_GAIN_MSB:0]  = pend_r[0];
                    rdata_nxt[`RPG_BIT_CHMUTE] = mute_r[0];
                end
                `RPG_ADDR_RGAIN: begin
                    rdata_nxt[`RPG_GAIN_MSB:0]  = pend_r[1];
                    rdata_nxt[`RPG_BIT_CHMUTE] = mute_r[1];
                end
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            conv_en_r <= 2'h0;
            gmute_r   <= 1'b0;
            hpf_en_r  <= 1'b0;
            cut_r     <= rpg_pkg::cut_dc;
            pend_r    <= {`RPG_GAIN_RST, `RPG_GAIN_RST};
            appl_r    <= {`RPG_GAIN_RST, `RPG_GAIN_RST};
            mute_r    <= 2'h0;
            rdata_r   <= 16'h0000;
        end else begin
            conv_en_r <= conv_en_nxt;
            gmute_r   <= gmute_nxt;
            hpf_en_r  <= hpf_en_nxt;
            cut_r     <= cut_nxt;
            pend_r    <= pend_nxt;
            appl_r    <= appl_nxt;
            mute_r    <= mute_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;

    // ------------------------------------------------------------
    // Per-channel processing
    // ------------------------------------------------------------
    logic        take;
    logic [47:0] in_pair;
    wire  [47:0] proc_w;
    logic [16:0] coef;

    assign take    = in_valid_i && in_ready_o;
    assign in_pair = {in_right_i, in_left_i};

    // Fixed pole per setting: corner tracks fs because the filter is discrete-time
    always_comb begin
        case (cut_r)
            rpg_pkg::cut_dc:   coef = `RPG_K_CUT0;
            rpg_pkg::cut_low:  coef = `RPG_K_CUT1;
            rpg_pkg::cut_mid:  coef = `RPG_K_CUT2;
            rpg_pkg::cut_high: coef = `RPG_K_CUT3;
            default:           coef = `RPG_K_CUT0;
        endcase
    end

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        rpg_pkg::rpg_acc_t   x1_r;
        rpg_pkg::rpg_acc_t   x1_nxt;
        rpg_pkg::rpg_acc_t   y1_r;
        rpg_pkg::rpg_acc_t   y1_nxt;
        rpg_pkg::rpg_acc_t   y2_r;
        rpg_pkg::rpg_acc_t   y2_nxt;
        rpg_pkg::rpg_acc_t   x;
        rpg_pkg::rpg_acc_t   d1;
        rpg_pkg::rpg_acc_t   d2;
        rpg_pkg::rpg_acc_t   filt;
        rpg_pkg::rpg_sample_t samp;
        rpg_pkg::rpg_sample_t res;
        logic signed [8:0]   expo;
        logic signed [8:0]   octave;
        logic [5:0]          amt;
        logic signed [39:0]  prod;
        logic signed [47:0]  wide;
        logic                silent;

        always_comb begin
            x  = rpg_pkg::rpg_acc_t'($signed(in_pair[ch*24 +: 24])) <<< `RPG_FRAC;
            // Leaky differentiators; second stage fed from first for 2nd order
            d1 = x - x1_r + y1_r - 40'((48'(y1_r) * $signed({1'b0, coef})) >>> 16);
            d2 = d1 - y1_r + y2_r - 40'((48'(y2_r) * $signed({1'b0, coef})) >>> 16);
            x1_nxt = x1_r;
            y1_nxt = y1_r;
            y2_nxt = y2_r;
            if (!hpf_en_r) begin
                filt   = x;
                x1_nxt = '0;
                y1_nxt = '0;
                y2_nxt = '0;
            end else begin
                filt = (cut_r == rpg_pkg::cut_dc) ? d1 : d2;
                if (take && conv_en_r[ch]) begin
                    x1_nxt = x;
                    y1_nxt = d1;
                    y2_nxt = (cut_r == rpg_pkg::cut_dc) ? 40'sh0 : d2;
                end
            end
            samp   = sat24(48'(filt >>> `RPG_FRAC));
            // Gain = 2^((X-192)/16): octave shift times table mantissa
            expo   = 9'($signed({1'b0, appl_r[ch]}) - $signed(`RPG_GAIN_UNITY));
            octave = expo >>> 4;
            amt    = 6'(`RPG_GAIN_SHIFT0 - octave[5:0]);
            prod   = samp * $signed({1'b0, gain_mant(expo[3:0])});
            wide   = $signed({{5{prod[39]}}, prod, 3'b000}) >>> amt;
            // Disabled channel reads as silence rather than stale data
            silent = !conv_en_r[ch] || gmute_r || mute_r[ch] || ~|appl_r[ch];
            res    = silent ? 24'sh00_0000 : sat24(wide);
        end

        always_ff @(posedge ref_clk_i) begin
            if (reset_i) begin
                x1_r <= '0;
                y1_r <= '0;
                y2_r <= '0;
            end else begin
                x1_r <= x1_nxt;
                y1_r <= y1_nxt;
                y2_r <= y2_nxt;
            end
        end

        assign proc_w[ch*24 +: 24] = res;
    end

    // ------------------------------------------------------------
    // Output buffer
    // ------------------------------------------------------------
    logic [47:0] out_pair;

    rpg_pair_buffer #(
        .WIDTH (48),
        .DEPTH (2)
    ) u_buf (
        .ref_clk_i   (ref_clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (in_valid_i),
        .in_data_i   (proc_w),
        .in_ready_o  (in_ready_o),
        .out_valid_o (out_valid_o),
        .out_data_o  (out_pair),
        .out_ready_i (out_ready_i)
    );

    assign out_left_o  = out_pair[23:0];
    assign out_right_o = out_pair[47:24];

endmodule

`default_nettype wire
